// >>> rtl/pfo_output.sv
// Purpose: pulse/frequency/switch output stage with Avalon-MM registers
// Assumes: process values arrive with a strobe; alarm is a level
// Notes: one wait cycle on every bus access; owed pulses saturate at 65535
`timescale 1ns/100ps
`default_nettype none
// Function
// - Output works as pulse, frequency or switch; pulse after reset.
// - Signal mode passive, active if built in, or fault-signalling; passive default.
// - Read-only report of the terminal pair in use or unused.
// - Pulse source off, volume, mass or corrected volume; off gives no pulses.
// - Pulse settings act only in pulse mode with a source assigned.
// - One pulse per scaling amount of accumulated quantity.
// - Pulse width 0.05 to 2000 ms, default 100 ms.
// - In alarm pulse mode keeps pulsing or suppresses pulses; suppress default.
// - Inversion flips output polarity in every mode; off by default.
// - Minimum and maximum frequency 0 to 10000 Hz, defaults 0 and 10000.
// - Two measured values map onto minimum and maximum frequency.
// - Frequency alarm gives actual, defined or zero frequency; zero default.
// - Failure frequency 0 to 12500 Hz, default 0.
module pfo_output #(
    parameter bit ACTIVE_OPT = 1'b1
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [5:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [3:0] avsByteEnable,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    // process side
    input wire pfo_pkg::pfo_pv_t pv,
    input wire logic alarm,
    input wire logic [1:0] terminalSel,
    // output pin
    output logic pinOut,
    output logic activeDrive
);
    pfo_pkg::pfo_st_t st_reg, st_next;
    pfo_pkg::pfo_cfg_t c;
    logic [31:0] oldWord, newWord, rd;
    logic signed [31:0] pvSel;
    logic [27:0] widthCyc;
    logic pulseOn, suppress, wave, level;
    logic [16:0] freqNow;

    pfo_freq_gen freqGen (
        .ref_clk(ref_clk),
        .rst(rst),
        .cfg(st_reg.cfg),
        .mv(pvSel),
        .sampleStb(pv.stb),
        .run(st_reg.cfg.mode == pfo_pkg::MODE_FREQ && st_reg.cfg.src != pfo_pkg::SRC_OFF),
        .forceEn(alarm && st_reg.cfg.ffail != pfo_pkg::FF_ACTUAL),
        .forceFreq(st_reg.cfg.ffail == pfo_pkg::FF_DEFINED ? st_reg.cfg.fFail : 17'h00000),
        .wave(wave),
        .freqNow(freqNow)
    );

    always_comb begin
        st_next = st_reg;
        c = st_reg.cfg;
        unique case (avsAddress)
            pfo_pkg::A_CTRL: rd = {21'h000000, c.switchOn, c.ffail, c.invert, c.pulseSuppress,
                c.src, c.sig, c.mode};
            pfo_pkg::A_TERM: rd = {30'h00000000, st_reg.term};
            pfo_pkg::A_SCALE: rd = c.scale;
            pfo_pkg::A_WIDTH: rd = {14'h0000, c.width};
            pfo_pkg::A_FMIN: rd = {15'h0000, c.fMin};
            pfo_pkg::A_FMAX: rd = {15'h0000, c.fMax};
            pfo_pkg::A_MVMIN: rd = c.mvMin;
            pfo_pkg::A_MVMAX: rd = c.mvMax;
            pfo_pkg::A_FFAIL: rd = {15'h0000, c.fFail};
            pfo_pkg::A_STAT: rd = {12'h000, st_reg.ps, st_reg.pin, st_reg.owed};
            pfo_pkg::A_FNOW: rd = {15'h0000, freqNow};
            default: rd = 32'h00000000;
        endcase
        oldWord = rd;
        for (int i = 0; i < 4; i++) begin
            newWord[i*8 +: 8] = avsByteEnable[i] ? avsWriteData[i*8 +: 8] : oldWord[i*8 +: 8];
        end
        // bus: one wait cycle, write lands on the edge after the one that ends the wait
        st_next.waitReq = !((avsRead || avsWrite) && st_reg.waitReq);
        if (avsRead && st_reg.waitReq) begin
            st_next.rdata = rd;
        end
        if (avsWrite && !st_reg.waitReq) begin
            unique case (avsAddress)
                pfo_pkg::A_CTRL: begin
                    if (newWord[pfo_pkg::C_MODE +: 2] != 2'h3) begin
                        c.mode = pfo_pkg::pfo_mode_t'(newWord[pfo_pkg::C_MODE +: 2]);
                    end
                    if (newWord[pfo_pkg::C_SIG +: 2] != 2'h3 &&
                        (ACTIVE_OPT || newWord[pfo_pkg::C_SIG +: 2] != 2'h1)) begin
                        c.sig = pfo_pkg::pfo_sig_t'(newWord[pfo_pkg::C_SIG +: 2]);
                    end
                    c.src = pfo_pkg::pfo_src_t'(newWord[pfo_pkg::C_SRC +: 2]);
                    c.pulseSuppress = newWord[pfo_pkg::C_SUPP];
                    c.invert = newWord[pfo_pkg::C_INV];
                    if (newWord[pfo_pkg::C_FFAIL +: 2] != 2'h3) begin
                        c.ffail = pfo_pkg::pfo_ffail_t'(newWord[pfo_pkg::C_FFAIL +: 2]);
                    end
                    c.switchOn = newWord[pfo_pkg::C_SWON];
                end
                pfo_pkg::A_SCALE: c.scale = newWord;
                pfo_pkg::A_WIDTH: c.width = newWord[31:18] != 14'h0000 ? pfo_pkg::PW_MAX :
                    newWord[17:0] < pfo_pkg::PW_MIN ? pfo_pkg::PW_MIN :
                    newWord[17:0] > pfo_pkg::PW_MAX ? pfo_pkg::PW_MAX : newWord[17:0];
                pfo_pkg::A_FMIN: c.fMin = newWord > 32'(pfo_pkg::F_LIM) ? pfo_pkg::F_LIM : newWord[16:0];
                pfo_pkg::A_FMAX: c.fMax = newWord > 32'(pfo_pkg::F_LIM) ? pfo_pkg::F_LIM : newWord[16:0];
                pfo_pkg::A_MVMIN: c.mvMin = newWord;
                pfo_pkg::A_MVMAX: c.mvMax = newWord;
                pfo_pkg::A_FFAIL: c.fFail = newWord > 32'(pfo_pkg::FAIL_LIM) ? pfo_pkg::FAIL_LIM :
                    newWord[16:0];
                default: c = st_reg.cfg;
            endcase
        end
        st_next.cfg = c;
        st_next.term = terminalSel;
        unique case (st_reg.cfg.src)
            pfo_pkg::SRC_VOL: pvSel = pv.vol;
            pfo_pkg::SRC_MASS: pvSel = pv.mass;
            pfo_pkg::SRC_CORR: pvSel = pv.corr;
            default: pvSel = 32'h00000000;
        endcase
        // pulse logic only with pulse mode and a source
        pulseOn = st_reg.cfg.mode == pfo_pkg::MODE_PULSE && st_reg.cfg.src != pfo_pkg::SRC_OFF;
        suppress = alarm && st_reg.cfg.pulseSuppress;
        widthCyc = 28'(st_reg.cfg.width) * 28'(pfo_pkg::PW_UNIT_CYC);
        if (!pulseOn || suppress) begin
            st_next.acc = 48'h000000000000;
            st_next.owed = 16'h0000;
        end else begin
            // one owed pulse per scaling amount
            if (st_reg.cfg.scale != 32'h00000000 && st_reg.acc >= 48'(st_reg.cfg.scale)) begin
                st_next.acc = st_reg.acc - 48'(st_reg.cfg.scale);
                if (st_reg.owed != 16'hFFFF) begin
                    st_next.owed = st_reg.owed + 16'h0001;
                end
            end
            if (pv.stb && !pvSel[31]) begin
                st_next.acc = st_next.acc + 48'(pvSel);
            end
        end
        // pulses back to back with a gap
        unique case (st_reg.ps)
            pfo_pkg::PS_IDLE: begin
                if (pulseOn && !suppress && st_reg.owed != 16'h0000) begin
                    st_next.ps = pfo_pkg::PS_HIGH;
                    st_next.cnt = widthCyc - 28'h0000001;
                    st_next.owed = st_next.owed - 16'h0001;
                end
            end
            pfo_pkg::PS_HIGH: begin
                st_next.cnt = st_reg.cnt - 28'h0000001;
                if (st_reg.cnt == 28'h0000000) begin
                    st_next.ps = pfo_pkg::PS_GAP;
                    st_next.cnt = widthCyc - 28'h0000001;
                end
            end
            pfo_pkg::PS_GAP: begin
                st_next.cnt = st_reg.cnt - 28'h0000001;
                if (st_reg.cnt == 28'h0000000) begin
                    st_next.ps = pfo_pkg::PS_IDLE;
                end
            end
            default: st_next.ps = pfo_pkg::PS_IDLE;
        endcase
        unique case (st_reg.cfg.mode)
            pfo_pkg::MODE_FREQ: level = wave;
            pfo_pkg::MODE_SWITCH: level = st_reg.cfg.switchOn;
            default: level = st_reg.ps == pfo_pkg::PS_HIGH;
        endcase
        // polarity flip, fault mode opens the output during alarm
        st_next.pin = (level ^ st_reg.cfg.invert) &&
            !(alarm && st_reg.cfg.sig == pfo_pkg::SIG_FAULT);
        st_next.drive = st_reg.cfg.sig == pfo_pkg::SIG_ACTIVE;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_reg <= '{1'b1, 32'h00000000, pfo_pkg::CFG_RST, 2'h0, 48'h000000000000, 16'h0000,
                pfo_pkg::PS_IDLE, 28'h0000000, 1'b0, 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign avsReadData = st_reg.rdata;
    assign avsWaitRequest = st_reg.waitReq;
    assign pinOut = st_reg.pin;
    assign activeDrive = st_reg.drive;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_reset_mode: assert property (disable iff (1'b0) rst |=> st_reg.cfg.mode ==
        pfo_pkg::MODE_PULSE && st_reg.cfg.src == pfo_pkg::SRC_OFF)
        else $error("wrong mode after reset");
    a_reset_signal: assert property (disable iff (1'b0) rst |=> !activeDrive &&
        st_reg.cfg.sig == pfo_pkg::SIG_PASSIVE && !st_reg.cfg.invert)
        else $error("wrong signal mode after reset");
    a_term_report: assert property (1'b1 |=> st_reg.term == $past(terminalSel))
        else $error("terminal report stale");
    a_bus_answer: assert property ((avsRead || avsWrite) && avsWaitRequest |=> // bus
        !avsWaitRequest ##1 avsWaitRequest)
        else $error("bus answer not after one wait cycle");
    a_no_source_idle: assert property (!pulseOn && st_reg.ps == pfo_pkg::PS_IDLE |=>
        st_reg.ps == pfo_pkg::PS_IDLE && st_reg.owed == 16'h0000)
        else $error("pulse without pulse mode and source");
    a_scale_owed: assert property (pulseOn && !alarm && st_reg.ps != pfo_pkg::PS_IDLE &&
        st_reg.cfg.scale != 32'h00000000 && st_reg.acc >= 48'(st_reg.cfg.scale) &&
        st_reg.owed != 16'hFFFF |=> st_reg.owed == $past(st_reg.owed) + 16'h0001)
        else $error("scaling amount not counted");
    a_width_start: assert property ($rose(st_reg.ps == pfo_pkg::PS_HIGH) |->
        st_reg.cnt == 28'(st_reg.cfg.width) * 28'(pfo_pkg::PW_UNIT_CYC) - 28'h0000001)
        else $error("pulse width load wrong");
    a_alarm_suppress: assert property (alarm && st_reg.cfg.pulseSuppress |=>
        st_reg.owed == 16'h0000 && !$rose(st_reg.ps == pfo_pkg::PS_HIGH))
        else $error("pulse emitted in suppressed alarm");
    a_invert_pin: assert property (st_reg.cfg.mode == pfo_pkg::MODE_SWITCH && !alarm &&
        $stable(st_reg.cfg) |=>
        pinOut == ($past(st_reg.cfg.switchOn) ^ $past(st_reg.cfg.invert)))
        else $error("switch level polarity wrong");
    a_gap_follows: assert property (st_reg.ps == pfo_pkg::PS_HIGH &&
        st_reg.cnt == 28'h0000000 |=> st_reg.ps == pfo_pkg::PS_GAP)
        else $error("no gap after pulse");
    c_pulse_emit: cover property ($rose(pinOut) && st_reg.cfg.mode == pfo_pkg::MODE_PULSE);
    c_back_to_back: cover property (st_reg.ps == pfo_pkg::PS_GAP && st_reg.owed != 16'h0000);
    c_freq_alarm: cover property (alarm && st_reg.cfg.mode == pfo_pkg::MODE_FREQ);
endmodule // pfo_output
`default_nettype wire

// >>> rtl/pfo_pkg.sv
// Purpose: shared constants and types of the pulse/frequency/switch output
// Assumes: 100 MHz ref_clk, byte-addressed Avalon-MM register words
// Notes: frequencies are held in units of 0.1 Hz, pulse width in 10 us units
package pfo_pkg;
    localparam int CLK_NS = 10;
    localparam int PW_UNIT_NS = 10000;
    localparam int PW_UNIT_CYC = PW_UNIT_NS / CLK_NS;
    localparam logic [17:0] PW_MIN = 18'h00005;
    localparam logic [17:0] PW_MAX = 18'h30D40;
    localparam logic [17:0] PW_RST = 18'h02710;
    localparam logic [16:0] F_LIM = 17'h186A0;
    localparam logic [16:0] FAIL_LIM = 17'h1E848;
    localparam logic [5:0] DIV_STEPS = 6'h32;
    localparam logic [8:0] NCO_MUL = 9'h113;
    localparam int NCO_SHIFT = 6;
    // register byte offsets
    localparam logic [5:0] A_CTRL = 6'h00;
    localparam logic [5:0] A_TERM = 6'h04;
    localparam logic [5:0] A_SCALE = 6'h08;
    localparam logic [5:0] A_WIDTH = 6'h0C;
    localparam logic [5:0] A_FMIN = 6'h10;
    localparam logic [5:0] A_FMAX = 6'h14;
    localparam logic [5:0] A_MVMIN = 6'h18;
    localparam logic [5:0] A_MVMAX = 6'h1C;
    localparam logic [5:0] A_FFAIL = 6'h20;
    localparam logic [5:0] A_STAT = 6'h24;
    localparam logic [5:0] A_FNOW = 6'h28;
    // control field positions
    localparam int C_MODE = 0;
    localparam int C_SIG = 2;
    localparam int C_SRC = 4;
    localparam int C_SUPP = 6;
    localparam int C_INV = 7;
    localparam int C_FFAIL = 8;
    localparam int C_SWON = 10;
    typedef enum logic [1:0] {MODE_PULSE = 2'h0, MODE_FREQ = 2'h1, MODE_SWITCH = 2'h2} pfo_mode_t;
    typedef enum logic [1:0] {SIG_PASSIVE = 2'h0, SIG_ACTIVE = 2'h1, SIG_FAULT = 2'h2} pfo_sig_t;
    typedef enum logic [1:0] {SRC_OFF = 2'h0, SRC_VOL = 2'h1, SRC_MASS = 2'h2, SRC_CORR = 2'h3} pfo_src_t;
    typedef enum logic [1:0] {FF_ACTUAL = 2'h0, FF_DEFINED = 2'h1, FF_ZERO = 2'h2} pfo_ffail_t;
    typedef enum logic [2:0] {PS_IDLE = 3'h1, PS_HIGH = 3'h2, PS_GAP = 3'h4} pfo_pst_t;
    typedef struct packed {
        pfo_mode_t mode;
        pfo_sig_t sig;
        pfo_src_t src;
        logic pulseSuppress;
        logic invert;
        pfo_ffail_t ffail;
        logic switchOn;
        logic [31:0] scale;
        logic [17:0] width;
        logic [16:0] fMin;
        logic [16:0] fMax;
        logic signed [31:0] mvMin;
        logic signed [31:0] mvMax;
        logic [16:0] fFail;
    } pfo_cfg_t;
    localparam pfo_cfg_t CFG_RST = '{MODE_PULSE, SIG_PASSIVE, SRC_OFF, 1'b1, 1'b0, FF_ZERO, 1'b0,
        32'h00000001, PW_RST, 17'h00000, F_LIM, 32'h00000000, 32'h00000064, 17'h00000};
    typedef struct packed {
        logic stb;
        logic signed [31:0] vol;
        logic signed [31:0] mass;
        logic signed [31:0] corr;
    } pfo_pv_t;
    typedef struct packed {
        logic busy;
        logic [5:0] cnt;
        logic [49:0] num;
        logic [33:0] rem;
        logic [32:0] den;
        logic [16:0] freq;
        logic [31:0] acc;
        logic wave;
    } pfo_fst_t;
    typedef struct packed {
        logic waitReq;
        logic [31:0] rdata;
        pfo_cfg_t cfg;
        logic [1:0] term;
        logic [47:0] acc;
        logic [15:0] owed;
        pfo_pst_t ps;
        logic [27:0] cnt;
        logic pin;
        logic drive;
    } pfo_st_t;
endpackage

// >>> rtl/pfo_freq_gen.sv
// Purpose: maps a measured value onto an output frequency and synthesises it
// Assumes: sampleStb marks a new measured value
// Notes: one divide takes 50 cycles; samples arriving meanwhile are skipped
`timescale 1ns/100ps
`default_nettype none
module pfo_freq_gen (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // settings and measured value
    input wire pfo_pkg::pfo_cfg_t cfg,
    input wire logic signed [31:0] mv,
    input wire logic sampleStb,
    input wire logic run,
    input wire logic forceEn,
    input wire logic [16:0] forceFreq,
    // output
    output logic wave,
    output logic [16:0] freqNow
);
    pfo_pkg::pfo_fst_t st_reg, st_next;
    logic signed [32:0] d, span;
    logic [16:0] fspan, fOut;
    logic [33:0] rem2;
    logic [25:0] prod;

    always_comb begin
        st_next = st_reg;
        d = 33'(mv) - 33'(cfg.mvMin);
        span = 33'(cfg.mvMax) - 33'(cfg.mvMin);
        fspan = (cfg.fMax > cfg.fMin) ? cfg.fMax - cfg.fMin : 17'h00000;
        rem2 = {st_reg.rem[32:0], st_reg.num[49]};
        if (sampleStb && !st_reg.busy) begin
            if (d <= 0 || span <= 0 || fspan == 17'h00000) begin
                st_next.freq = cfg.fMin;
            end else if (d >= span) begin
                st_next.freq = cfg.fMax;
            end else begin
                st_next.busy = 1'b1;
                st_next.cnt = pfo_pkg::DIV_STEPS;
                st_next.num = 50'(d[31:0]) * 50'(fspan);
                st_next.rem = 34'h000000000;
                st_next.den = span[32:0];
            end
        end
        if (st_reg.busy) begin
            if (rem2 >= {1'b0, st_reg.den}) begin
                st_next.rem = rem2 - {1'b0, st_reg.den};
                st_next.num = {st_reg.num[48:0], 1'b1};
            end else begin
                st_next.rem = rem2;
                st_next.num = {st_reg.num[48:0], 1'b0};
            end
            st_next.cnt = st_reg.cnt - 6'h01;
            if (st_reg.cnt == 6'h01) begin
                st_next.busy = 1'b0;
                st_next.freq = cfg.fMin + st_next.num[16:0];
            end
        end
        fOut = forceEn ? forceFreq : st_reg.freq;
        prod = 26'(fOut) * 26'(pfo_pkg::NCO_MUL);
        if (run) begin
            st_next.acc = st_reg.acc + 32'(prod >> pfo_pkg::NCO_SHIFT);
        end else begin
            st_next.acc = 32'h00000000;
        end
        st_next.wave = run && st_next.acc[31];
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign wave = st_reg.wave;
    assign freqNow = st_reg.freq;

    a_freq_clamp: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(st_reg.busy) |-> st_reg.freq >= cfg.fMin && st_reg.freq <= cfg.fMax)
        else $error("interpolated frequency outside limits");
    a_freq_stopped: assert property (@(posedge ref_clk) disable iff (rst)
        !run |=> !st_reg.wave && st_reg.acc == 32'h00000000)
        else $error("wave running while not selected");
    c_divide_done: cover property (@(posedge ref_clk) disable iff (rst) $fell(st_reg.busy));
endmodule // pfo_freq_gen
`default_nettype wire

// >>> bench/pfo_counter.sv
// Purpose: external counter input seen by the output pin
// Assumes: sense is sampled on ref_clk, no glitches shorter than a cycle
// Notes: lastHigh is the length of the last active level, minLow the shortest gap
`timescale 1ns/100ps
`default_nettype none
module pfo_counter (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // counter input
    input wire logic clr,
    input wire logic sense,
    // results
    output int pulses,
    output int lastHigh,
    output int minLow
);
    int run;
    logic prev;
    logic seen;
    always @(posedge ref_clk) begin
        if (rst || clr) begin
            pulses <= 0;
            lastHigh <= 0;
            minLow <= 32'h7FFFFFFF;
            run <= 0;
            seen <= 1'b0;
            prev <= sense;
        end else begin
            prev <= sense;
            if (sense !== prev) begin
                run <= 1;
                if (sense) begin
                    pulses <= pulses + 1;
                    if (seen && run < minLow) minLow <= run;
                end else begin
                    lastHigh <= run;
                    seen <= 1'b1;
                end
            end else begin
                run <= run + 1;
            end
        end
    end
endmodule // pfo_counter
`default_nettype wire

// >>> bench/tb.sv
// Purpose: self-checking bench of the pulse/frequency/switch output
// Assumes: one wait cycle per bus access, width counted in 1000-cycle units
// Notes: minimum pulse width used so pulse trains stay short
`timescale 1ns/100ps
`default_nettype none
module tb;
    typedef struct packed {
        logic wr;
        logic [5:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } pfotb_row_t;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] avsAddress = 6'h00;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWriteData = 32'h00000000;
    logic [3:0] avsByteEnable = 4'hF;
    logic [31:0] avsReadData;
    logic avsWaitRequest;
    pfo_pkg::pfo_pv_t pv = '0;
    logic alarm = 1'b0;
    logic [1:0] terminalSel = 2'h2;
    logic pinOut;
    logic activeDrive;
    logic cntClr = 1'b0;
    int pulses;
    int lastHigh;
    int minLow;
    int n_errors = 0;
    int checked = 0;
    logic [31:0] rd;
    pfotb_row_t rows [12];
    always #5 ref_clk = ~ref_clk;
    pfo_output #(.ACTIVE_OPT(1'b1)) dut (.ref_clk(ref_clk), .rst(rst),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .pv(pv),
        .alarm(alarm), .terminalSel(terminalSel), .pinOut(pinOut), .activeDrive(activeDrive));
    pfo_counter peer (.ref_clk(ref_clk), .rst(rst), .clr(cntClr), .sense(pinOut),
        .pulses(pulses), .lastHigh(lastHigh), .minLow(minLow));
    task automatic results;
        if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            n_errors++;
        end
    endtask
    // request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int i;
        avsAddress <= a;
        avsWrite <= wr;
        avsRead <= ~wr;
        avsWriteData <= d;
        i = 0;
        do begin
            @(posedge ref_clk);
            i++;
        end while (avsWaitRequest !== 1'b0 && i < 50);
        rd = avsReadData;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        if (i >= 50) begin
            n_errors++;
            results();
        end
        // one idle edge so the next request is a fresh assignment
        @(posedge ref_clk);
    endtask
    task automatic rdchk(input string name, input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h00000000);
        chk(name, e, rd);
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic sendPv(input logic [31:0] v, input logic [31:0] m, input logic [31:0] c);
        pv <= '{1'b1, v, m, c};
        @(posedge ref_clk);
        pv <= '0;
    endtask
    initial begin
        repeat (98000) @(posedge ref_clk);
        n_errors++;
        results();
    end
    initial begin
        rows[0] = '{1'b0, pfo_pkg::A_CTRL, 32'h0, 32'h00000240};
        rows[1] = '{1'b0, pfo_pkg::A_SCALE, 32'h0, 32'h00000001};
        rows[2] = '{1'b0, pfo_pkg::A_WIDTH, 32'h0, 32'h00002710};
        rows[3] = '{1'b0, pfo_pkg::A_FMIN, 32'h0, 32'h00000000};
        rows[4] = '{1'b0, pfo_pkg::A_FMAX, 32'h0, 32'h000186A0};
        rows[5] = '{1'b0, pfo_pkg::A_FFAIL, 32'h0, 32'h00000000};
        rows[6] = '{1'b0, 6'h3C, 32'h0, 32'h00000000};
        rows[7] = '{1'b1, pfo_pkg::A_TERM, 32'h00000003, 32'h0};
        rows[8] = '{1'b0, pfo_pkg::A_TERM, 32'h0, 32'h00000002};
        rows[9] = '{1'b1, pfo_pkg::A_WIDTH, 32'h00000003, 32'h0};
        rows[10] = '{1'b0, pfo_pkg::A_WIDTH, 32'h0, 32'h00000005};
        rows[11] = '{1'b1, pfo_pkg::A_FFAIL, 32'h000FFFFF, 32'h0};
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        chk("pinOut", 32'h0, {31'h0, pinOut});
        chk("waitReq", 32'h1, {31'h0, avsWaitRequest});
        foreach (rows[k]) begin
            if (rows[k].wr) bus(1'b1, rows[k].a, rows[k].d);
            else rdchk("row", rows[k].a, rows[k].e);
        end
        rdchk("ffail", pfo_pkg::A_FFAIL, 32'h0001E848);
        terminalSel <= 2'h0;
        waitc(2);
        rdchk("term", pfo_pkg::A_TERM, 32'h00000000);
        bus(1'b1, pfo_pkg::A_SCALE, 32'h0000000A);
        bus(1'b1, pfo_pkg::A_CTRL, 32'h00000250);
        cntClr <= 1'b1;
        waitc(1);
        cntClr <= 1'b0;
        sendPv(32'd25, 32'd0, 32'd0);
        waitc(20100);
        chk("pulses", 32'd2, pulses);
        chk("width", 32'd5000, lastHigh);
        chk("gap", 32'h1, {31'h0, minLow >= 5000});
        sendPv(32'd5, 32'd0, 32'd0);
        waitc(10100);
        chk("pulses", 32'd3, pulses);
        bus(1'b1, pfo_pkg::A_CTRL, 32'h00000260);
        sendPv(32'd100, 32'd10, 32'd0);
        waitc(10100);
        chk("pulses", 32'd4, pulses);
        bus(1'b1, pfo_pkg::A_CTRL, 32'h00000270);
        sendPv(32'd0, 32'd0, 32'd10);
        waitc(10100);
        chk("pulses", 32'd5, pulses);
        bus(1'b1, pfo_pkg::A_CTRL, 32'h00000240);
        sendPv(32'd100, 32'd100, 32'd100);
        waitc(10100);
        chk("pulses", 32'd5, pulses);
        bus(1'b1, pfo_pkg::A_CTRL, 32'h00000250);
        alarm <= 1'b1;
        sendPv(32'd100, 32'd0, 32'd0);
        waitc(10100);
        chk("pulses", 32'd5, pulses);
        bus(1'b1, pfo_pkg::A_CTRL, 32'h00000210);
        sendPv(32'd10, 32'd0, 32'd0);
        waitc(10100);
        chk("pulses", 32'd6, pulses);
        alarm <= 1'b0;
        bus(1'b1, pfo_pkg::A_CTRL, 32'h00000290);
        waitc(3);
        chk("pinOut", 32'h1, {31'h0, pinOut});
        bus(1'b1, pfo_pkg::A_CTRL, 32'h00000402);
        waitc(3);
        chk("pinOut", 32'h1, {31'h0, pinOut});
        bus(1'b1, pfo_pkg::A_CTRL, 32'h00000482);
        waitc(3);
        chk("pinOut", 32'h0, {31'h0, pinOut});
        bus(1'b1, pfo_pkg::A_CTRL, 32'h00000406);
        waitc(3);
        chk("activeDrive", 32'h1, {31'h0, activeDrive});
        bus(1'b1, pfo_pkg::A_CTRL, 32'h0000040A);
        alarm <= 1'b1;
        waitc(3);
        chk("pinOut", 32'h0, {31'h0, pinOut});
        alarm <= 1'b0;
        waitc(3);
        chk("pinOut", 32'h1, {31'h0, pinOut});
        bus(1'b1, pfo_pkg::A_CTRL, 32'h00000211);
        sendPv(32'd50, 32'd0, 32'd0);
        waitc(60);
        rdchk("fnow", pfo_pkg::A_FNOW, 32'h0000C350);
        sendPv(32'd200, 32'd0, 32'd0);
        waitc(60);
        rdchk("fnow", pfo_pkg::A_FNOW, 32'h000186A0);
        bus(1'b1, pfo_pkg::A_FMIN, 32'h000003E8);
        sendPv(32'hFFFFFFF6, 32'd0, 32'd0);
        waitc(60);
        rdchk("fnow", pfo_pkg::A_FNOW, 32'h000003E8);
        // alarm swaps in the failure frequency, nco restarted from zero
        bus(1'b1, pfo_pkg::A_CTRL, 32'h00000240);
        cntClr <= 1'b1;
        alarm <= 1'b1;
        bus(1'b1, pfo_pkg::A_CTRL, 32'h00000111);
        cntClr <= 1'b0;
        waitc(9000);
        chk("pulses", 32'd1, pulses);
        // reset in mid-run restores the defaults
        alarm <= 1'b0;
        rst <= 1'b1;
        waitc(3);
        rst <= 1'b0;
        chk("pinOut", 32'h0, {31'h0, pinOut});
        rdchk("ctrl", pfo_pkg::A_CTRL, 32'h00000240);
        rdchk("width", pfo_pkg::A_WIDTH, 32'h00002710);
        results();
    end
endmodule // tb
`default_nettype wire
